// ### rtl/gpio_pin_irq.v
// Added by the designer: strobed register access.
`include "gpio_pin_irq_map.vh"

// Notes on behaviour
// - port2_input_mode bit 7 picks pull-up (0) or pull-down (1) for port 2.
// - port2_input_mode bit 6 picks pull-up (0) or pull-down (1) for port 1.
// - port2_input_mode bit 5 picks pull-up (0) or pull-down (1) for port 0.
// - bits 4:0 choose pulled (0) or tristate (1) per port 2 pin; reset zero.
// - a port 0 pin's pending request sets its flag; flags reset to zero.
// - a port 1 pin's pending request sets its flag; flags reset to zero.
// - port 2 pins 4:0 set flags; flag bits 7:5 read zero.
// - control bit 6 selects minimum (0) or maximum (1) output drive.
// - control bit 5 enables port 2 pin requests as a group.
// - control bit 4 enables port 0 pins 7:4 requests as a group.
// - control bit 3 enables port 0 pins 3:0 requests as a group.
// - control bit 2 picks rising (0) or falling (1) edge for port 2.
// - control bit 1 picks rising (0) or falling (1) edge for port 1.
// - control bit 0 picks rising (0) or falling (1) edge for port 0.
// - port 1 per-pin mask enables each pin's request; resets to zero.
// - each port 0 pin is pulled (0) or tristate (1), shared direction bit.
module gpio_pin_irq (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // pins from the pads
  input  wire [7:0] port0_pins,
  input  wire [7:0] port1_pins,
  input  wire [4:0] port2_pins,
  // pad configuration
  output wire [7:0] port0_pull_enable,
  output wire       port0_pull_direction,
  output wire       port1_pull_direction,
  output wire [4:0] port2_pull_enable,
  output wire       port2_pull_direction,
  output wire       pad_drive_strength_select,
  // interrupt requests
  output wire       port0_irq,
  output wire       port1_irq,
  output wire       port2_irq,
  output wire       irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // software-visible state

  reg  [7:0] port2_input_mode;
  reg  [7:0] port_irq_control;
  reg  [7:0] port0_pin_input_mode;
  reg  [7:0] port1_pin_irq_mask;
  reg  [7:0] port0_pending_flags;
  reg  [7:0] port1_pending_flags;
  reg  [4:0] port2_pending_flags;
  reg  [7:0] event_status;
  reg  [7:0] event_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // decoded strobes

  wire       wr_p0_flags = wr && (addr == `ADDR_PORT0_IRQ_FLAGS);
  wire       wr_p1_flags = wr && (addr == `ADDR_PORT1_IRQ_FLAGS);
  wire       wr_p2_flags = wr && (addr == `ADDR_PORT2_IRQ_FLAGS);
  wire       wr_control  = wr && (addr == `ADDR_PORT_IRQ_CONTROL);
  wire       wr_p1_mask  = wr && (addr == `ADDR_PORT1_IRQ_MASK);
  wire       wr_p0_mode  = wr && (addr == `ADDR_PORT0_INPUT_MODE);
  wire       wr_p2_mode  = wr && (addr == `ADDR_PORT2_INPUT_MODE);
  wire       wr_ev_mask  = wr && (addr == `ADDR_EVENT_MASK);
  wire       rd_ev_stat  = rd && (addr == `ADDR_EVENT_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration fields

  wire       port2_pull_dir   = port2_input_mode[`P2INM_PULL_DIR2_BIT];
  wire       port1_pull_dir   = port2_input_mode[`P2INM_PULL_DIR1_BIT];
  wire       port0_pull_dir   = port2_input_mode[`P2INM_PULL_DIR0_BIT];
  wire [4:0] port2_pin_input_mode = port2_input_mode[`P2INM_MODE_MSB:0];

  wire       port2_group_irq_enable = port_irq_control[`CTRL_P2_EN_BIT];
  wire       port0_upper_irq_enable = port_irq_control[`CTRL_P0_HI_EN_BIT];
  wire       port0_lower_irq_enable = port_irq_control[`CTRL_P0_LO_EN_BIT];
  wire       port2_edge_select      = port_irq_control[`CTRL_P2_EDGE_BIT];
  wire       port1_edge_select      = port_irq_control[`CTRL_P1_EDGE_BIT];
  wire       port0_edge_select      = port_irq_control[`CTRL_P0_EDGE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // pad controls

  assign port2_pull_direction = port2_pull_dir;
  assign port1_pull_direction = port1_pull_dir;
  assign port0_pull_direction = port0_pull_dir;
  assign port2_pull_enable    = ~port2_pin_input_mode;
  assign port0_pull_enable    = ~port0_pin_input_mode;
  assign pad_drive_strength_select = port_irq_control[`CTRL_DRIVE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  // all pins side by side: port2 high, port0 low
  wire [`ALL_PINS-1:0] pins_raw = {port2_pins, port1_pins, port0_pins};

  // per-pin falling-edge choice spread from the three port bits
  wire [`ALL_PINS-1:0] pin_falling = {{`PORT2_PINS{port2_edge_select}},
                                      {8{port1_edge_select}},
                                      {8{port0_edge_select}}};

  reg  [`ALL_PINS-1:0] pin_meta;
  reg  [`ALL_PINS-1:0] pin_sync;
  reg  [`ALL_PINS-1:0] pin_last;
  reg  [1:0]           prime_count;
  wire                 primed = (prime_count == `PRIME_CYCLES);
  wire [`ALL_PINS-1:0] pin_edge;

  // edges are ignored until the pipeline holds real pin levels, so a pin
  // already high at reset does not look like a rising edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prime_count <= 2'h0;
    end else if (!primed) begin
      prime_count <= prime_count + 2'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `ALL_PINS; i = i + 1) begin : g_pin
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_meta[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
          pin_last[i] <= 1'b0;
        end else begin
          pin_meta[i] <= pins_raw[i];
          pin_sync[i] <= pin_meta[i];
          pin_last[i] <= pin_sync[i];
        end
      end
      // rising when the select bit is 0, falling when 1
      assign pin_edge[i] = primed &&
                           (pin_falling[i] ? (pin_last[i] & ~pin_sync[i])
                                           : (pin_sync[i] & ~pin_last[i]));
    end
  endgenerate

  wire [7:0] p0_edge = pin_edge[7:0];
  wire [7:0] p1_edge = pin_edge[15:8];
  wire [4:0] p2_edge = pin_edge[20:16];

  ////////////////////////////////////////////////////////////////////////////////
  // pending flags: hardware set wins over a software clear in the same cycle

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port0_pending_flags <= `FLAGS_RESET;
      port1_pending_flags <= `FLAGS_RESET;
      port2_pending_flags <= 5'h00;
    end else begin
      if (wr_p0_flags) begin
        port0_pending_flags <= (port0_pending_flags & wdata) | p0_edge;
      end else begin
        port0_pending_flags <= port0_pending_flags | p0_edge;
      end
      if (wr_p1_flags) begin
        port1_pending_flags <= (port1_pending_flags & wdata) | p1_edge;
      end else begin
        port1_pending_flags <= port1_pending_flags | p1_edge;
      end
      if (wr_p2_flags) begin
        port2_pending_flags <= (port2_pending_flags & wdata[4:0]) | p2_edge;
      end else begin
        port2_pending_flags <= port2_pending_flags | p2_edge;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // group and per-pin enables gate the pending flags onto the port requests

  wire [7:0] port0_enable = {{4{port0_upper_irq_enable}},
                             {4{port0_lower_irq_enable}}};
  wire [7:0] port0_active = port0_pending_flags & port0_enable;
  wire [7:0] port1_active = port1_pending_flags & port1_pin_irq_mask;
  wire [4:0] port2_active = port2_pending_flags &
                            {`PORT2_PINS{port2_group_irq_enable}};

  // a flag may sit pending while disabled; enabling later raises the request
  assign port0_irq = |port0_active;
  assign port1_irq = |port1_active;
  assign port2_irq = |port2_active;

  // one event per port whenever an enabled pin takes a new edge
  wire [7:0] event_set = {5'h00,
                          |(p2_edge & {`PORT2_PINS{port2_group_irq_enable}}),
                          |(p1_edge & port1_pin_irq_mask),
                          |(p0_edge & port0_enable)};

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port2_input_mode     <= `P2INM_RESET;
      port_irq_control     <= `CTRL_RESET;
      port0_pin_input_mode <= `P0_MODE_RESET;
      port1_pin_irq_mask   <= `P1_IRQ_MASK_RESET;
      event_mask           <= `EVENT_RESET;
    end else begin
      if (wr_p2_mode) begin
        port2_input_mode <= wdata & `P2INM_WRITE_MASK;
      end
      if (wr_control) begin
        port_irq_control <= wdata & `CTRL_WRITE_MASK;
      end
      if (wr_p0_mode) begin
        port0_pin_input_mode <= wdata;
      end
      if (wr_p1_mask) begin
        port1_pin_irq_mask <= wdata;
      end
      if (wr_ev_mask) begin
        event_mask <= wdata & `EVENT_WRITE_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event status: a read clears it, an event in the same cycle survives

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      event_status <= `EVENT_RESET;
    end else if (rd_ev_stat) begin
      event_status <= event_set;
    end else begin
      event_status <= event_status | event_set;
    end
  end

  assign irq = |(event_status & event_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped offsets read zero

  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `ADDR_PORT0_IRQ_FLAGS:  next_rdata = port0_pending_flags;
      `ADDR_PORT1_IRQ_FLAGS:  next_rdata = port1_pending_flags;
      `ADDR_PORT2_IRQ_FLAGS:  next_rdata = {3'h0, port2_pending_flags};
      `ADDR_PORT_IRQ_CONTROL: next_rdata = port_irq_control;
      `ADDR_PORT1_IRQ_MASK:   next_rdata = port1_pin_irq_mask;
      `ADDR_PORT0_INPUT_MODE: next_rdata = port0_pin_input_mode;
      `ADDR_PORT2_INPUT_MODE: next_rdata = port2_input_mode;
      `ADDR_EVENT_STATUS:     next_rdata = event_status;
      `ADDR_EVENT_MASK:       next_rdata = event_mask;
      default:                next_rdata = 8'h00;
    endcase
  end

  // rdata only carries data in the cycle after a read; zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // gpio_pin_irq

// ### rtl/gpio_pin_irq_map.vh
`ifndef GPIO_PIN_IRQ_MAP_VH
`define GPIO_PIN_IRQ_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets on the 8-bit register port
`define ADDR_PORT0_IRQ_FLAGS    8'h89
`define ADDR_PORT1_IRQ_FLAGS    8'h8A
`define ADDR_PORT2_IRQ_FLAGS    8'h8B
`define ADDR_PORT_IRQ_CONTROL   8'h8C
`define ADDR_PORT1_IRQ_MASK     8'h8D
`define ADDR_PORT0_INPUT_MODE   8'h8F
`define ADDR_PORT2_INPUT_MODE   8'hF7
`define ADDR_EVENT_STATUS       8'hE0
`define ADDR_EVENT_MASK         8'hE1

////////////////////////////////////////////////////////////////////////////////
// port2_input_mode fields
`define P2INM_PULL_DIR2_BIT     7
`define P2INM_PULL_DIR1_BIT     6
`define P2INM_PULL_DIR0_BIT     5
`define P2INM_MODE_MSB          4
`define P2INM_WRITE_MASK        8'hFF
`define P2INM_RESET             8'h00

////////////////////////////////////////////////////////////////////////////////
// port_irq_control fields
`define CTRL_DRIVE_BIT          6
`define CTRL_P2_EN_BIT          5
`define CTRL_P0_HI_EN_BIT       4
`define CTRL_P0_LO_EN_BIT       3
`define CTRL_P2_EDGE_BIT        2
`define CTRL_P1_EDGE_BIT        1
`define CTRL_P0_EDGE_BIT        0
`define CTRL_WRITE_MASK         8'h7F
`define CTRL_RESET              8'h00

////////////////////////////////////////////////////////////////////////////////
// other reset values and widths
`define FLAGS_RESET             8'h00
`define P2_FLAGS_MASK           8'h1F
`define P0_MODE_RESET           8'h00
`define P1_IRQ_MASK_RESET       8'h00
`define EVENT_RESET             8'h00
`define EVENT_WRITE_MASK        8'h07
`define PORT2_PINS              5
`define ALL_PINS                21
`define PRIME_CYCLES            2'h3

`endif

// ### verification/gpio_pin_irq_checker.sv
`include "gpio_pin_irq_map.vh"
module gpio_pin_irq_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // pad configuration
  input wire logic [7:0] port0_pull_enable,
  input wire logic       port0_pull_direction,
  input wire logic       port1_pull_direction,
  input wire logic [4:0] port2_pull_enable,
  input wire logic       port2_pull_direction,
  input wire logic       pad_drive_strength_select,
  // requests
  input wire logic       port0_irq,
  input wire logic       port1_irq,
  input wire logic       port2_irq,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_mode2 = wr && addr == `ADDR_PORT2_INPUT_MODE;
  wire logic wr_mode0 = wr && addr == `ADDR_PORT0_INPUT_MODE;
  wire logic wr_ctl   = wr && addr == `ADDR_PORT_IRQ_CONTROL;
  wire logic wr_mask1 = wr && addr == `ADDR_PORT1_IRQ_MASK;
  ////////////////////////////////////////////////////////////////////////////////
  chk_dir2_follow:
    assert property ($past(wr_mode2) |-> port2_pull_direction == $past(wdata[7]))
    else $error("port 2 pull direction missed a write");
  chk_dir1_follow:
    assert property ($past(wr_mode2) |-> port1_pull_direction == $past(wdata[6]))
    else $error("port 1 pull direction missed a write");
  chk_dir0_follow:
    assert property ($past(wr_mode2) |-> port0_pull_direction == $past(wdata[5]))
    else $error("port 0 pull direction missed a write");
  chk_mode2_pull:
    assert property ($past(wr_mode2) |-> port2_pull_enable == ~$past(wdata[4:0]))
    else $error("port 2 pull enables wrong after write");
  chk_mode0_pull:
    assert property ($past(wr_mode0) |-> port0_pull_enable == ~$past(wdata))
    else $error("port 0 pull enables wrong after write");
  chk_drive_select:
    assert property ($past(wr_ctl) |-> pad_drive_strength_select == $past(wdata[6]))
    else $error("drive strength missed a write");
  chk_flag2_unused:
    assert property ($past(rd && addr == `ADDR_PORT2_IRQ_FLAGS) |-> rdata[7:5] == 3'h0)
    else $error("unused port 2 flag bits read nonzero");
  chk_p2_group_off:
    assert property ($past(wr_ctl && !wdata[5]) |-> !port2_irq)
    else $error("port 2 request while group disabled");
  chk_p0_group_off:
    assert property ($past(wr_ctl && wdata[4:3] == 2'h0) |-> !port0_irq)
    else $error("port 0 request while both groups disabled");
  chk_p1_mask_off:
    assert property ($past(wr_mask1 && wdata == 8'h00) |-> !port1_irq)
    else $error("port 1 request while all pins masked");
  cover property ($rose(irq));
  cover property ($rose(port0_irq));
  cover property ($rose(port2_irq));
endmodule // gpio_pin_irq_checker

bind gpio_pin_irq gpio_pin_irq_checker chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .port0_pull_enable(port0_pull_enable),
  .port0_pull_direction(port0_pull_direction), .port1_pull_direction(port1_pull_direction),
  .port2_pull_enable(port2_pull_enable), .port2_pull_direction(port2_pull_direction),
  .pad_drive_strength_select(pad_drive_strength_select), .port0_irq(port0_irq),
  .port1_irq(port1_irq), .port2_irq(port2_irq), .irq(irq));

// ### verification/gpio_pin_irq_tb.sv
`include "gpio_pin_irq_map.vh"
module gpio_pin_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd, rd_seen;
  logic [7:0]  addr, wdata, v, hot, fa;
  logic [20:0] want;
  logic [31:0] seed;
  logic [7:0]  exp_q [$];
  wire  [7:0]  rdata, p0, p1, p0_pull;
  wire  [4:0]  p2, p2_pull;
  wire         d0, d1, d2, drive, i0, i1, i2, irq;
  int          fails, n_tests, port, e, pin;
  localparam logic [7:0] reset_reads [10] = '{`ADDR_PORT0_IRQ_FLAGS, `ADDR_PORT1_IRQ_FLAGS,
    `ADDR_PORT2_IRQ_FLAGS, `ADDR_PORT_IRQ_CONTROL, `ADDR_PORT1_IRQ_MASK, `ADDR_PORT0_INPUT_MODE,
    `ADDR_PORT2_INPUT_MODE, `ADDR_EVENT_STATUS, `ADDR_EVENT_MASK, 8'h00};
  pin_model pins (.clk(clk), .want(want), .port0_pins(p0), .port1_pins(p1), .port2_pins(p2));
  gpio_pin_irq DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port0_pins(p0), .port1_pins(p1), .port2_pins(p2),
    .port0_pull_enable(p0_pull), .port0_pull_direction(d0), .port1_pull_direction(d1),
    .port2_pull_enable(p2_pull), .port2_pull_direction(d2), .pad_drive_strength_select(drive),
    .port0_irq(i0), .port1_irq(i1), .port2_irq(i2), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input [7:0] seen, input [7:0] expected);
    n_tests++;
    if (seen !== expected) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask
  // each task waits an edge first, so back-to-back calls never reassign a strobe in one step
  task automatic bus_wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input [7:0] a, input [7:0] expected);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(expected);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe, so the monitor looks exactly there
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end
  initial begin
    {rst, wr, rd, rd_seen, addr, wdata, want, fails, n_tests} = '0;
    rst  = 1'b1;
    seed = 32'h4;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) bus_rd(reset_reads[i], 8'h00);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = seed[7:0];
      bus_wr(`ADDR_PORT2_INPUT_MODE, v);
      bus_wr(`ADDR_PORT0_INPUT_MODE, ~v);
      bus_wr(`ADDR_PORT_IRQ_CONTROL, v);
      bus_wr(`ADDR_PORT1_IRQ_MASK, ~v);
      bus_rd(`ADDR_PORT2_INPUT_MODE, v);
      bus_rd(`ADDR_PORT_IRQ_CONTROL, v & `CTRL_WRITE_MASK);
      bus_rd(`ADDR_PORT1_IRQ_MASK, ~v);
      check({5'h0, d2, d1, d0}, {5'h0, v[7:5]});
      check({3'h0, p2_pull}, {3'h0, ~v[4:0]});
      check(p0_pull, v);
      check({7'h0, drive}, {7'h0, v[6]});
    end
    for (e = 0; e < 2; e++) begin
      bus_wr(`ADDR_PORT_IRQ_CONTROL, {5'b00111, {3{e[0]}}});
      bus_wr(`ADDR_PORT1_IRQ_MASK, 8'hFF);
      bus_wr(`ADDR_EVENT_MASK, e ? 8'h00 : 8'h07);
      for (port = 0; port < 3; port++) begin
        // idle at the level the selected edge leaves; the move there is the wrong edge
        want <= {21{e[0]}};
        repeat (6) @(posedge clk);
        for (int f = 0; f < 3; f++) bus_wr(`ADDR_PORT0_IRQ_FLAGS + f[7:0], 8'h00);
        seed = xs(seed);
        pin = (port == 2) ? seed % 5 : seed % 8;
        hot = 8'h01 << pin;
        fa = `ADDR_PORT0_IRQ_FLAGS + port[7:0];
        want[port * 8 + pin] <= ~e[0];
        repeat (6) @(posedge clk);
        check({5'h0, i2, i1, i0}, 8'h01 << port);
        check({7'h0, irq}, {7'h0, ~e[0]});
        bus_rd(fa, hot);
        bus_rd(`ADDR_EVENT_STATUS, 8'h01 << port);
        bus_rd(`ADDR_EVENT_STATUS, 8'h00);
        check({7'h0, irq}, 8'h00);
        want[port * 8 + pin] <= e[0];
        repeat (6) @(posedge clk);
        bus_wr(fa, 8'hFF);
        bus_rd(fa, hot);
        bus_wr(fa, ~hot);
        bus_rd(fa, 8'h00);
        check({5'h0, i2, i1, i0}, 8'h00);
      end
    end
    bus_wr(`ADDR_PORT_IRQ_CONTROL, 8'h00);
    bus_wr(`ADDR_PORT1_IRQ_MASK, 8'h00);
    repeat (3) @(posedge clk);
    wrap_up;
  end
endmodule // gpio_pin_irq_tb

// ### verification/pin_model.sv
module pin_model (
  // clock
  input  wire logic        clk,
  // levels asked for, port 2 on top
  input  wire logic [20:0] want,
  // pad levels
  output logic      [7:0]  port0_pins,
  output logic      [7:0]  port1_pins,
  output logic      [4:0]  port2_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // the pads lag one cycle, like a slow external driver; levels are held far longer than 2 cycles
  initial {port2_pins, port1_pins, port0_pins} = 21'h0;
  always @(posedge clk) begin
    {port2_pins, port1_pins, port0_pins} <= want;
  end
endmodule // pin_model
